//--- logic/sft_pkg.sv
// How it works
// - The output line is bi-phase-mark coded, so each bit cell carries clock and data.
// - A frame is two sub-frames, one per stereo channel, sent back to back.
// - Each sub-frame opens with a preamble that marks block starts apart from other sub-frames.
// - A 4-bit auxiliary field follows the preamble, least significant bit first.
// - A 20-bit audio field follows, LSB first, making a 24-bit sample with the auxiliary field.
// - The validity bit is 1 for invalid sample data and 0 for valid data.
// - Each sub-frame holds one user bit and one channel-status bit, building blocks over 192 frames.
// - The last bit is parity, giving even parity over all bits except the preamble.
// - A block spans 192 frames and only the first 40 carry register channel-status content; user bits are sent in every frame.
// - A two-bit source select, reset 00, picks receiver, ADC, secondary or primary interface.
// - With source 00, the overwrite bit picks recovered status (0) or register status (1).
// - With the through bit set the pin carries the input-mux stream, otherwise the transmitter.
// - The transmitter power-down bit resets to 1 and disables the transmitter while set.
// - Validity is sent as 0 except with source 00, where the recovered validity is forwarded.
// - User bits are sent as 0 except with source 00, where recovered user bits are forwarded.
// - Channel status goes one bit per sub-frame, the same for both channels but the channel number.
package sft_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [6:0] ADDR_TX_SOURCE_CONTROL = 7'h1E;
  localparam logic [6:0] ADDR_CHAN_STATUS_1 = 7'h1F;
  localparam logic [6:0] ADDR_CHAN_STATUS_2 = 7'h20;
  localparam logic [6:0] ADDR_CHAN_STATUS_3 = 7'h21;
  localparam logic [6:0] ADDR_CHAN_STATUS_4 = 7'h22;
  localparam logic [6:0] ADDR_CHAN_STATUS_5 = 7'h23;
  localparam logic [6:0] ADDR_BLOCK_POWER_DOWN_2 = 7'h33;
  localparam int SRC_LSB = 0;
  localparam int OVW_BIT = 2;
  localparam int THROUGH_BIT = 3;
  localparam int TXPD_BIT = 4;
  localparam logic [7:0] RST_TX_SOURCE_CONTROL = 8'h00;
  localparam logic [7:0] RST_CS1 = 8'h00;
  localparam logic [7:0] RST_CS2 = 8'h00;
  localparam logic [7:0] RST_CS3 = 8'h00;
  localparam logic [7:0] RST_CS4 = 8'h31;
  localparam logic [7:0] RST_CS5 = 8'h01;
  localparam logic [7:0] RST_BLOCK_POWER_DOWN_2 = 8'h10;
  // ----------------------------------------------------------------
  // Sources and frame layout
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_RECEIVER = 2'h0;
  localparam logic [4:0] SLOT_PRE_LAST = 5'h03;
  localparam logic [4:0] SLOT_VALID = 5'h1C;
  localparam logic [4:0] SLOT_USER = 5'h1D;
  localparam logic [4:0] SLOT_CHAN = 5'h1E;
  localparam logic [4:0] SLOT_PARITY = 5'h1F;
  localparam logic [7:0] FRAME_LAST = 8'hBF;
  localparam logic [7:0] CS_FRAMES = 8'h28;
  localparam logic [7:0] PRE_BLOCK = 8'hE8;
  localparam logic [7:0] PRE_SUB1 = 8'hE2;
  localparam logic [7:0] PRE_SUB2 = 8'hE4;
  // ----------------------------------------------------------------
  // Timing: half-cell rate from the 25 MHz clock
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 25000000;
  localparam int HALF_CELL_HZ = 6250000;
  localparam logic [3:0] HALF_DIV = 4'((CLOCK_HZ + HALF_CELL_HZ - 1) / HALF_CELL_HZ);
  typedef enum logic [1:0] {TX_OFF = 2'b00, TX_START = 2'b01, TX_RUN = 2'b11} sft_state_t;
endpackage

//--- logic/sft_tx_top.sv
`timescale 1ns/10ps
`default_nettype none
module sft_tx_top import sft_pkg::*; (
  // Clock and reset
  input wire logic CLOCK,
  input wire logic RST_N,
  // Register port
  input wire logic REG_WE,
  input wire logic [6:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  // Sample sources, index 0 is sub-frame 1
  input wire logic [23:0] RX_SAMPLE_L,
  input wire logic [23:0] RX_SAMPLE_R,
  input wire logic [23:0] ADC_SAMPLE_L,
  input wire logic [23:0] ADC_SAMPLE_R,
  input wire logic [23:0] AIF2_SAMPLE_L,
  input wire logic [23:0] AIF2_SAMPLE_R,
  input wire logic [23:0] AIF1_SAMPLE_L,
  input wire logic [23:0] AIF1_SAMPLE_R,
  input wire logic [1:0] RX_VALIDITY,
  input wire logic [1:0] RX_USER,
  input wire logic [1:0] RX_CHAN_STATUS,
  // Serial line
  input wire logic IN_MUX_STREAM,
  output logic SERIAL_AUDIO_OUT_PIN
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] tx_source_control_reg, block_power_down_2_reg;
  logic [7:0] cs1_reg, cs2_reg, cs3_reg, cs4_reg, cs5_reg, rdata_reg;
  logic [1:0] tx_source_select;
  logic chan_status_overwrite, through_mode, transmitter_power_down;
  assign tx_source_select = tx_source_control_reg[SRC_LSB +: 2];
  assign chan_status_overwrite = tx_source_control_reg[OVW_BIT];
  assign through_mode = tx_source_control_reg[THROUGH_BIT];
  assign transmitter_power_down = block_power_down_2_reg[TXPD_BIT];

  // Register writes; unknown addresses are ignored
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      tx_source_control_reg <= RST_TX_SOURCE_CONTROL;
      block_power_down_2_reg <= RST_BLOCK_POWER_DOWN_2;
      cs1_reg <= RST_CS1;
      cs2_reg <= RST_CS2;
      cs3_reg <= RST_CS3;
      cs4_reg <= RST_CS4;
      cs5_reg <= RST_CS5;
    end else if (REG_WE) begin
      unique case (REG_ADDR)
        ADDR_TX_SOURCE_CONTROL: tx_source_control_reg <= {4'h0, REG_WDATA[3:0]};
        ADDR_BLOCK_POWER_DOWN_2: block_power_down_2_reg <= REG_WDATA & RST_BLOCK_POWER_DOWN_2;
        ADDR_CHAN_STATUS_1: cs1_reg <= REG_WDATA;
        ADDR_CHAN_STATUS_2: cs2_reg <= REG_WDATA;
        ADDR_CHAN_STATUS_3: cs3_reg <= REG_WDATA;
        ADDR_CHAN_STATUS_4: cs4_reg <= REG_WDATA;
        ADDR_CHAN_STATUS_5: cs5_reg <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // Read-back, one cycle after the address
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      rdata_reg <= 8'h00;
    end else begin
      unique case (REG_ADDR)
        ADDR_TX_SOURCE_CONTROL: rdata_reg <= tx_source_control_reg;
        ADDR_BLOCK_POWER_DOWN_2: rdata_reg <= block_power_down_2_reg;
        ADDR_CHAN_STATUS_1: rdata_reg <= cs1_reg;
        ADDR_CHAN_STATUS_2: rdata_reg <= cs2_reg;
        ADDR_CHAN_STATUS_3: rdata_reg <= cs3_reg;
        ADDR_CHAN_STATUS_4: rdata_reg <= cs4_reg;
        ADDR_CHAN_STATUS_5: rdata_reg <= cs5_reg;
        default: rdata_reg <= 8'h00;
      endcase
    end
  end
  assign REG_RDATA = rdata_reg;

  // ----------------------------------------------------------------
  // Power state and half-cell divider
  // ----------------------------------------------------------------
  sft_state_t state_reg;
  logic [3:0] div_reg;
  logic en_reg, run;
  assign run = (state_reg == TX_RUN);

  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      state_reg <= TX_OFF;
    end else if (transmitter_power_down) begin
      state_reg <= TX_OFF;
    end else begin
      unique case (state_reg)
        TX_OFF: state_reg <= TX_START;
        TX_START: state_reg <= TX_RUN;
        TX_RUN: state_reg <= TX_RUN;
        default: state_reg <= TX_OFF;
      endcase
    end
  end

  // One-cycle enable per half cell
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      div_reg <= 4'h0;
      en_reg <= 1'b0;
    end else if (!run) begin
      div_reg <= 4'h0;
      en_reg <= 1'b0;
    end else begin
      en_reg <= (div_reg == HALF_DIV - 4'h1);
      div_reg <= (div_reg == HALF_DIV - 4'h1) ? 4'h0 : div_reg + 4'h1;
    end
  end

  // ----------------------------------------------------------------
  // Frame position: slot, half, sub-frame, frame in block
  // ----------------------------------------------------------------
  logic [4:0] slot_reg;
  logic half_reg, sub_reg;
  logic [7:0] frame_reg;

  // two sub-frames per frame; 192-frame block
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      slot_reg <= 5'h00;
      half_reg <= 1'b0;
      sub_reg <= 1'b0;
      frame_reg <= 8'h00;
    end else if (!run) begin
      slot_reg <= 5'h00;
      half_reg <= 1'b0;
      sub_reg <= 1'b0;
      frame_reg <= 8'h00;
    end else if (en_reg) begin
      half_reg <= ~half_reg;
      if (half_reg) begin
        slot_reg <= slot_reg + 5'h01;
        if (slot_reg == SLOT_PARITY) begin
          sub_reg <= ~sub_reg;
          if (sub_reg) begin
            frame_reg <= (frame_reg == FRAME_LAST) ? 8'h00 : frame_reg + 8'h01;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Sample and status selection
  // ----------------------------------------------------------------
  // Maps a two-bit channel-number field to status bits 23:20
  function automatic logic [3:0] chan_num(input logic [1:0] code);
    chan_num = (code == 2'h1) ? 4'h1 : ((code == 2'h2) ? 4'h2 : 4'h0);
  endfunction

  logic [39:0] cs_vec;
  logic [23:0] sample;
  logic v_bit, u_bit, c_bit, reg_c_bit;
  logic [23:0] sample_reg;
  logic v_reg, u_reg, c_reg;

  // same status for both channels except the channel number
  assign cs_vec = {cs5_reg, cs4_reg,
                   sub_reg ? chan_num(cs3_reg[7:6]) : chan_num(cs3_reg[5:4]),
                   cs3_reg[3:0], cs2_reg, cs1_reg};
  // content only in the first 40 frames
  assign reg_c_bit = (frame_reg < CS_FRAMES) ? cs_vec[frame_reg[5:0]] : 1'b0;

  always_comb begin
    unique case (tx_source_select)
      2'h0: sample = sub_reg ? RX_SAMPLE_R : RX_SAMPLE_L;
      2'h1: sample = sub_reg ? ADC_SAMPLE_R : ADC_SAMPLE_L;
      2'h2: sample = sub_reg ? AIF2_SAMPLE_R : AIF2_SAMPLE_L;
      2'h3: sample = sub_reg ? AIF1_SAMPLE_R : AIF1_SAMPLE_L;
    endcase
  end

  // validity; user; status overwrite; V polarity, one U and C bit
  assign v_bit = (tx_source_select == SRC_RECEIVER) ? RX_VALIDITY[sub_reg] : 1'b0;
  assign u_bit = (tx_source_select == SRC_RECEIVER) ? RX_USER[sub_reg] : 1'b0;
  assign c_bit = (tx_source_select == SRC_RECEIVER && !chan_status_overwrite) ?
                 RX_CHAN_STATUS[sub_reg] : reg_c_bit;

  // Latch the sub-frame payload during the preamble so a source change mid-word cannot tear it
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      sample_reg <= 24'h000000;
      v_reg <= 1'b0;
      u_reg <= 1'b0;
      c_reg <= 1'b0;
    end else if (en_reg && slot_reg == 5'h00 && !half_reg) begin
      sample_reg <= sample;
      v_reg <= v_bit;
      u_reg <= u_bit;
      c_reg <= c_bit;
    end
  end

  // ----------------------------------------------------------------
  // Bit selection, parity and bi-phase-mark coding
  // ----------------------------------------------------------------
  logic [7:0] pre_pat;
  logic [2:0] pre_idx;
  logic cur_bit, lvl, line_reg, pre_lvl_reg, par_reg;

  // block-start pattern only for sub-frame 1 of frame 0
  assign pre_pat = sub_reg ? PRE_SUB2 : ((frame_reg == 8'h00) ? PRE_BLOCK : PRE_SUB1);
  assign pre_idx = 3'h7 - {slot_reg[1:0], half_reg};

  always_comb begin
    if (slot_reg == SLOT_PARITY) begin
      cur_bit = par_reg;
    end else if (slot_reg == SLOT_CHAN) begin
      cur_bit = c_reg;
    end else if (slot_reg == SLOT_USER) begin
      cur_bit = u_reg;
    end else if (slot_reg == SLOT_VALID) begin
      cur_bit = v_reg;
    end else if (slot_reg > SLOT_PRE_LAST) begin
      cur_bit = sample_reg[slot_reg - 5'h04];
    end else begin
      cur_bit = 1'b0;
    end
  end

  // bi-phase-mark levels; preambles are relative to the previous level
  always_comb begin
    if (slot_reg <= SLOT_PRE_LAST) begin
      lvl = pre_pat[pre_idx] ^ pre_lvl_reg;
    end else if (!half_reg) begin
      lvl = ~line_reg;
    end else begin
      lvl = cur_bit ? ~line_reg : line_reg;
    end
  end

  // Line level and level at sub-frame end
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      line_reg <= 1'b0;
      pre_lvl_reg <= 1'b0;
    end else if (!run) begin
      line_reg <= 1'b0;
      pre_lvl_reg <= 1'b0;
    end else if (en_reg) begin
      line_reg <= lvl;
      if (slot_reg == SLOT_PARITY && half_reg) begin
        pre_lvl_reg <= lvl;
      end
    end
  end

  // running parity over slots 4 to 30; cleared after the parity cell has used it and while not running
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      par_reg <= 1'b0;
    end else if (!run || (en_reg && slot_reg == SLOT_PARITY && half_reg)) begin
      par_reg <= 1'b0;
    end else if (en_reg && !half_reg && slot_reg > SLOT_PRE_LAST && slot_reg != SLOT_PARITY) begin
      par_reg <= par_reg ^ cur_bit;
    end
  end

  // ----------------------------------------------------------------
  // Through mode and output pin
  // ----------------------------------------------------------------
  logic mux_s1_reg, mux_s2_reg, out_reg;

  // Two-flop synchroniser for the input-mux stream
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      mux_s1_reg <= 1'b0;
      mux_s2_reg <= 1'b0;
    end else begin
      mux_s1_reg <= IN_MUX_STREAM;
      mux_s2_reg <= mux_s1_reg;
    end
  end

  // through bypass; otherwise idle low while powered down
  always_ff @(posedge CLOCK or negedge RST_N) begin
    if (!RST_N) begin
      out_reg <= 1'b0;
    end else begin
      out_reg <= through_mode ? mux_s2_reg : (run & line_reg);
    end
  end
  assign SERIAL_AUDIO_OUT_PIN = out_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_cell_edge;
    @(posedge CLOCK) disable iff (!RST_N)
    en_reg && run && slot_reg > SLOT_PRE_LAST && !half_reg |=> line_reg != $past(line_reg);
  endproperty
  a_cell_edge: assert property (p_cell_edge) else $error("no edge at cell start");

  property p_mid_zero;
    @(posedge CLOCK) disable iff (!RST_N)
    en_reg && run && slot_reg > SLOT_PRE_LAST && half_reg && !cur_bit |=> $stable(line_reg);
  endproperty
  a_mid_zero: assert property (p_mid_zero) else $error("zero bit has mid edge");

  property p_sub_turn;
    @(posedge CLOCK) disable iff (!RST_N)
    en_reg && run && slot_reg == SLOT_PARITY && half_reg |=> sub_reg != $past(sub_reg);
  endproperty
  a_sub_turn: assert property (p_sub_turn) else $error("sub-frame did not turn");

  property p_block_wrap;
    @(posedge CLOCK) disable iff (!RST_N)
    en_reg && run && half_reg && slot_reg == SLOT_PARITY && sub_reg && frame_reg == FRAME_LAST
    |=> frame_reg == 8'h00;
  endproperty
  a_block_wrap: assert property (p_block_wrap) else $error("block did not wrap at 192");

  property p_valid_zero;
    @(posedge CLOCK) disable iff (!RST_N)
    en_reg && slot_reg == 5'h00 && !half_reg && tx_source_select != SRC_RECEIVER |=> !v_reg;
  endproperty
  a_valid_zero: assert property (p_valid_zero) else $error("validity not zero");

  property p_user_zero;
    @(posedge CLOCK) disable iff (!RST_N)
    en_reg && slot_reg == 5'h00 && !half_reg && tx_source_select != SRC_RECEIVER |=> !u_reg;
  endproperty
  a_user_zero: assert property (p_user_zero) else $error("user bit not zero");

  property p_power_down;
    @(posedge CLOCK) disable iff (!RST_N)
    transmitter_power_down && !through_mode ##1 !through_mode |=> ##1 !SERIAL_AUDIO_OUT_PIN;
  endproperty
  a_power_down: assert property (p_power_down) else $error("line active while down");

  property p_through;
    @(posedge CLOCK) disable iff (!RST_N)
    through_mode |=> SERIAL_AUDIO_OUT_PIN == $past(mux_s2_reg);
  endproperty
  a_through: assert property (p_through) else $error("through path broken");

  c_block: cover property (@(posedge CLOCK) disable iff (!RST_N) run && frame_reg == FRAME_LAST);
  c_through: cover property (@(posedge CLOCK) disable iff (!RST_N) through_mode);
  c_ovw: cover property (@(posedge CLOCK) disable iff (!RST_N) run && chan_status_overwrite);
endmodule
`default_nettype wire

//--- tb/sft_rx_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------------------------------
// Receiving equipment: decodes the line by run lengths
// ----------------------------------------------------------------
module sft_rx_model (
  // Clock, reset and line
  input wire logic clk,
  input wire logic rst_n,
  input wire logic line,
  // Sub-frame seen: kind 0 block start, 1 sub-frame 1, 2 sub-frame 2, 3 bad
  output logic sub_valid,
  output logic [1:0] sub_kind,
  output logic [27:0] sub_bits
);
  logic line_q;
  logic pend;
  logic [1:0] kind;
  logic [27:0] sh;
  int cnt, r, mode, halves, nbits, pre;
  // Runs are counted in half cells, so no bit clock has to be recovered
  // line decode
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode = 0;
      cnt = 0;
      line_q <= 1'b0;
      sub_valid <= 1'b0;
      sub_kind <= 2'h3;
      sub_bits <= 28'h0;
    end else begin
      sub_valid <= 1'b0;
      line_q <= line;
      cnt = cnt + 1;
      if (line != line_q) begin
        r = (cnt + 2) / 4;
        cnt = 0;
        if (mode == 1) begin
          halves = halves + r;
          pre = pre * 4 + r;
          if (halves >= 8) begin
            mode = 2;
            nbits = 0;
            pend = 1'b0;
            kind = (pre == 23) ? 2'h0 : (pre == 53) ? 2'h1 : (pre == 38) ? 2'h2 : 2'h3;
          end
        end else if (r == 3) begin
          mode = 1;
          halves = 3;
          pre = 0;
        end else if (mode == 2 && (r == 2 || (r == 1 && pend))) begin
          sh = {(r == 1), sh[27:1]};
          pend = 1'b0;
          nbits = nbits + 1;
          if (nbits == 28) begin
            sub_valid <= 1'b1;
            sub_kind <= kind;
            sub_bits <= sh;
            mode = 0;
          end
        end else if (mode == 2 && r == 1) begin
          pend = 1'b1;
        end else begin
          mode = 0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- tb/sft_tx_top_tb.sv
`timescale 1ns/10ps
`default_nettype none
module sft_tx_top_tb import sft_pkg::*;;
  logic clock, rst_n, reg_we, in_mux, pin, m_valid;
  logic [6:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [23:0] rx_l, rx_r, adc_l, adc_r, aif2_l, aif2_r, aif1_l, aif1_r;
  logic [1:0] rx_v, rx_u, rx_c, m_kind;
  logic [27:0] m_bits;
  logic [39:0] cs_vec [2];
  int num_errors, tests_run, cyc, fnum;
  // ----------------------------------------------------------------
  // Design, receiver and clock
  // ----------------------------------------------------------------
  sft_tx_top uut (.CLOCK(clock), .RST_N(rst_n), .REG_WE(reg_we), .REG_ADDR(reg_addr),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata), .RX_SAMPLE_L(rx_l), .RX_SAMPLE_R(rx_r),
    .ADC_SAMPLE_L(adc_l), .ADC_SAMPLE_R(adc_r), .AIF2_SAMPLE_L(aif2_l),
    .AIF2_SAMPLE_R(aif2_r), .AIF1_SAMPLE_L(aif1_l), .AIF1_SAMPLE_R(aif1_r),
    .RX_VALIDITY(rx_v), .RX_USER(rx_u), .RX_CHAN_STATUS(rx_c),
    .IN_MUX_STREAM(in_mux), .SERIAL_AUDIO_OUT_PIN(pin));
  sft_rx_model rx_model (.clk(clock), .rst_n(rst_n), .line(pin), .sub_valid(m_valid),
    .sub_kind(m_kind), .sub_bits(m_bits));
  // Free-running clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Cut a hang short; the full run needs about 28000 cycles
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      num_errors++;
      complete_run();
    end
  end
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge clock);
    reg_we = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clock);
    reg_we = 1'b0;
  endtask
  task automatic rd_check(input logic [6:0] a, input logic [7:0] exp);
    @(negedge clock);
    reg_addr = a;
    @(negedge clock);
    check("register", {24'h0, reg_rdata}, {24'h0, exp});
  endtask
  // Waits for one decoded sub-frame; the frame counter restarts at a block start
  task automatic get_sub(output logic [1:0] k, output logic [27:0] b);
    int n;
    n = 0;
    @(negedge clock);
    while (m_valid !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    check("sub-frame arrival", {31'h0, m_valid}, 32'h1);
    k = m_kind;
    b = m_bits;
    if (k === 2'h0) fnum = 0;
    else if (k === 2'h1) fnum++;
  endtask
  task automatic get_pair(output logic [27:0] b1, output logic [27:0] b2);
    logic [1:0] k;
    get_sub(k, b1);
    if (k === 2'h2) get_sub(k, b1);
    check("first sub-frame kind", {31'h0, k[1]}, 32'h0);
    get_sub(k, b2);
    check("second sub-frame kind", {30'h0, k}, 32'h2);
  endtask
  task automatic check_sub(input logic [27:0] b, input logic [23:0] s, input logic [2:0] cuv);
    check("sample", {8'h0, b[23:0]}, {8'h0, s});
    check("trailer bits", {29'h0, b[26:24]}, {29'h0, cuv});
    check("parity", {31'h0, ^b}, 32'h0);
  endtask
  // Only the first 40 frames carry status, later ones send 0
  function automatic logic cs_exp(input int ch);
    return (fnum < 40) ? cs_vec[ch][fnum] : 1'b0;
  endfunction
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic scen_reset();
    rd_check(ADDR_TX_SOURCE_CONTROL, 8'h00);
    rd_check(ADDR_CHAN_STATUS_4, 8'h31);
    rd_check(ADDR_CHAN_STATUS_5, 8'h01);
    rd_check(ADDR_BLOCK_POWER_DOWN_2, 8'h10);
    wr(7'h10, 8'hAA);
    rd_check(7'h10, 8'h00);
    check("pin while powered down", {31'h0, pin}, 32'h0);
  endtask
  task automatic scen_adc();
    logic [27:0] b1, b2;
    cs_vec[0] = {8'h01, 8'h31, 4'h1, 4'h0, 8'h00, 8'h05};
    cs_vec[1] = {8'h01, 8'h31, 4'h2, 4'h0, 8'h00, 8'h05};
    wr(ADDR_CHAN_STATUS_1, 8'h05);
    wr(ADDR_CHAN_STATUS_3, 8'h90);
    wr(ADDR_TX_SOURCE_CONTROL, 8'h01);
    wr(ADDR_BLOCK_POWER_DOWN_2, 8'h00);
    for (int f = 0; f < 44; f++) begin
      get_pair(b1, b2);
      check("frame number", fnum, f);
      check_sub(b1, adc_l, {cs_exp(0), 2'b00});
      check_sub(b2, adc_r, {cs_exp(1), 2'b00});
    end
  endtask
  task automatic scen_recovered();
    logic [27:0] b1, b2;
    rx_v = 2'b01;
    rx_u = 2'b10;
    rx_c = 2'b11;
    wr(ADDR_TX_SOURCE_CONTROL, 8'h00);
    get_pair(b1, b2);
    get_pair(b1, b2);
    check_sub(b1, rx_l, 3'b101);
    check_sub(b2, rx_r, 3'b110);
    wr(ADDR_TX_SOURCE_CONTROL, 8'h04);
    get_pair(b1, b2);
    get_pair(b1, b2);
    check_sub(b1, rx_l, {cs_exp(0), 2'b01});
    check_sub(b2, rx_r, {cs_exp(1), 2'b10});
  endtask
  task automatic scen_interfaces();
    logic [27:0] b1, b2;
    for (int s = 2; s < 4; s++) begin
      wr(ADDR_TX_SOURCE_CONTROL, 8'(s));
      get_pair(b1, b2);
      get_pair(b1, b2);
      check_sub(b1, (s == 2) ? aif2_l : aif1_l, {cs_exp(0), 2'b00});
      check_sub(b2, (s == 2) ? aif2_r : aif1_r, {cs_exp(1), 2'b00});
    end
  endtask
  task automatic scen_through();
    int bad;
    wr(ADDR_TX_SOURCE_CONTROL, 8'hFF);
    rd_check(ADDR_TX_SOURCE_CONTROL, 8'h0F);
    for (int i = 1; i < 5; i++) begin
      in_mux = i[0];
      repeat (5) @(negedge clock);
      check("through pin", {31'h0, pin}, {31'h0, in_mux});
    end
    wr(ADDR_BLOCK_POWER_DOWN_2, 8'hFF);
    rd_check(ADDR_BLOCK_POWER_DOWN_2, 8'h10);
    wr(ADDR_TX_SOURCE_CONTROL, 8'h00);
    bad = 0;
    repeat (600) begin
      @(negedge clock);
      if (pin !== 1'b0) bad++;
    end
    check("pin after power-down", bad, 0);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and verdict
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    rst_n = 1'b0;
    reg_we = 1'b0;
    reg_addr = 7'h00;
    reg_wdata = 8'h00;
    rx_l = 24'hA5A5A1;
    rx_r = 24'h5A5A5E;
    adc_l = 24'h800001;
    adc_r = 24'h7FFFFE;
    aif2_l = 24'h0F0F0F;
    aif2_r = 24'hF0F0F0;
    aif1_l = 24'hC3C3C3;
    aif1_r = 24'h3C3C3C;
    rx_v = 2'b00;
    rx_u = 2'b00;
    rx_c = 2'b00;
    in_mux = 1'b0;
    fnum = 99;
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    scen_reset();
    scen_adc();
    scen_recovered();
    scen_interfaces();
    scen_through();
    complete_run();
  end
endmodule
`default_nettype wire
